/* File: dv/dbt_cpu_model.sv */
// behavioural cpu bus and opcode execution model
`timescale 1ns/1ps
module dbt_cpu_model
    import dbt_pkg::*;
(
    input wire logic clock_in,
    output dbt_cpu_bus_s bus_out,
    output dbt_exec_s exec_out
);
    // idle lines show inverted values so a stale address never matches
    initial begin
        bus_out = '{1'b0, 1'b1, 16'hffff, 8'hff};
        exec_out = '{1'b0, 16'hffff};
    end
    // one bus cycle, then a quiet cycle
    task automatic access(input logic [15:0] a, input logic [7:0] d);
        bus_out <= '{1'b1, 1'b0, a, d};
        @(posedge clock_in);
        bus_out <= '{1'b0, 1'b1, ~a, ~d};
        @(posedge clock_in);
    endtask : access
    // one executed opcode pulse, then a quiet cycle
    task automatic exec(input logic [15:0] a);
        exec_out <= '{1'b1, a};
        @(posedge clock_in);
        exec_out <= '{1'b0, ~a};
        @(posedge clock_in);
    endtask : exec
endmodule : dbt_cpu_model

/* File: dv/dbt_top_props.sv */
// assertion checker on the ports of the debug trigger block
`timescale 1ns/1ps
`include "dbt_map.svh"
module dbt_top_props
    import dbt_pkg::*;
#(
    parameter int DEPTH = 8
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire dbt_cpu_bus_s cpu_bus_in,
    input wire dbt_exec_s cpu_exec_in,
    input wire logic armed_out,
    input wire logic trigger_out
);
    logic ph_q;
    logic ph_w_q;
    logic [11:0] ph_a_q;
    // data phase tracker, so data lines up with its address phase
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            ph_q <= 1'b0;
        end else if (hready_in) begin
            ph_q <= hsel_in && htrans_in[1];
        end
    end
    always_ff @(posedge clock_in) begin
        if (hready_in) begin
            ph_w_q <= hwrite_in;
            ph_a_q <= haddr_in[11:0];
        end
    end
    // decoded data phases
    wire wr_ctrl = ph_q && ph_w_q && ph_a_q == `DBT_OFS_CTRL;
    wire rd_stat = ph_q && !ph_w_q && ph_a_q == `DBT_OFS_STAT;
    wire rd_trig = ph_q && !ph_w_q && ph_a_q == `DBT_OFS_TRIG;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);

    a_arm_start: assert property (wr_ctrl && hwdata_in[7:6] == 2'b11 |-> ##2 armed_out)
        else $error("arm write did not raise armed");
    a_arm_cause: assert property ($rose(armed_out) |-> $past(wr_ctrl))
        else $error("armed rose without a control write");
    a_stop_write: assert property (wr_ctrl && hwdata_in[7:6] != 2'b11 |-> ##2 !armed_out [*3])
        else $error("stop write left the run armed");
    a_trig_armed: assert property (trigger_out |-> $past(armed_out))
        else $error("trigger while disarmed");
    a_trig_cause: assert property (trigger_out |-> $past(cpu_bus_in.valid) || $past(cpu_exec_in.valid))
        else $error("trigger without a cpu cycle");
    a_stat_mirror: assert property (rd_stat |-> hrdata_out[5] == armed_out)
        else $error("status armed bit differs from armed");
    a_stat_zero: assert property (rd_stat |-> hrdata_out[31:8] == 24'h0 && !hrdata_out[4])
        else $error("status unused bits not zero");
    a_trig_zero: assert property (rd_trig |-> hrdata_out[31:8] == 24'h0 && hrdata_out[5:4] == 2'b00)
        else $error("trigger word bits 5 and 4 not zero");
    a_count_max: assert property (rd_stat |-> hrdata_out[3:0] <= DEPTH)
        else $error("valid count above fifo depth");
endmodule : dbt_top_props

/* File: dv/tb_top.sv */
// self-checking bench for the debug trigger block
`timescale 1ns/1ps
`include "dbt_map.svh"
module tb_top
    import dbt_pkg::*;
;
    logic clock_in;
    logic reset_n_in;
    logic hsel;
    logic [2:0] hsize;
    logic hwrite;
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] q;
    logic [7:0] msk;
    logic hreadyout;
    logic armed;
    logic trigger;
    dbt_cpu_bus_s cpu_bus;
    dbt_exec_s cpu_exec;
    int miscompares;
    int cmp_count;
    int trig_cnt;
    // cpu cycles of the mode sweep, expected pulses and status for modes 0 to 8
    logic [15:0] s_adr [5] = '{16'h0800, 16'h2000, 16'h1000, 16'h2000, 16'h1000};
    logic [7:0] s_dat [5] = '{8'h11, 8'h22, 8'h5a, 8'h44, 8'h00};
    int e_trg [9] = '{1, 1, 1, 2, 1, 1, 1, 1, 1};
    logic [7:0] e_st [9] = '{8'h00, 8'h40, 8'hc0, 8'h22, 8'h21, 8'h00, 8'h00, 8'h00, 8'h00};

    dbt_top #(.DEPTH(8)) dut (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(),
        .cpu_bus_in(cpu_bus), .cpu_exec_in(cpu_exec), .armed_out(armed), .trigger_out(trigger)
    );
    dbt_cpu_model mdl (.clock_in(clock_in), .bus_out(cpu_bus), .exec_out(cpu_exec));

    // 10 MHz clock
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end
    // trigger pulses counted mid-cycle, clear of the edge updates
    always @(negedge clock_in) begin
        if (trigger === 1'b1) trig_cnt++;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // one single transfer; waits on hready, read data taken at the data phase edge
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        hsize <= 3'b010;
        htrans <= 2'b10;
        haddr <= {20'h0, a};
        hwrite <= w;
        do @(posedge clock_in); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clock_in); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic bw(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : bw
    task automatic br(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : br
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // watchdog: twenty thousand cycles, the tests need about five hundred
    initial begin
        #2_000_000;
        miscompares++;
        stop_test();
    end

    initial begin
        reset_n_in = 1'b0;
        hsel = 1'b0;
        hsize = 3'b010;
        hwrite = 1'b0;
        htrans = 2'b00;
        haddr = 32'h0;
        hwdata = 32'h0;
        miscompares = 0;
        cmp_count = 0;
        trig_cnt = 0;
        repeat (16) @(posedge clock_in);
        reset_n_in <= 1'b1;
        @(posedge clock_in);
        // every word reads zero after reset, unmapped one included
        for (int i = 0; i < 8; i++) br(12'(i * 4), 32'h0);
        $display("test reset done");
        // trigger word locks while armed, status ignores writes
        bw(`DBT_OFS_TRIG, 32'hff);
        br(`DBT_OFS_TRIG, 32'hcf);
        bw(`DBT_OFS_CTRL, 32'hc0);
        br(`DBT_OFS_STAT, 32'h20);
        bw(`DBT_OFS_TRIG, 32'h00);
        br(`DBT_OFS_TRIG, 32'hcf);
        bw(`DBT_OFS_STAT, 32'hff);
        br(`DBT_OFS_STAT, 32'h20);
        bw(`DBT_OFS_CTRL, 32'h40);
        br(`DBT_OFS_STAT, 32'h00);
        $display("test access done");
        bw(`DBT_OFS_COMP_A, 32'h1000);
        bw(`DBT_OFS_COMP_B, 32'h2000);
        // all sixteen mode codes as force type with the begin bit clear, end traces except event modes 3 and 4; flags checked where unambiguous
        for (int m = 0; m < 16; m++) begin
            msk = (m == 1 || m == 2) ? 8'hff : 8'h3f;
            bw(`DBT_OFS_TRIG, 32'(m));
            bw(`DBT_OFS_CTRL, 32'hc0);
            br(`DBT_OFS_STAT, 32'h20);
            trig_cnt = 0;
            for (int s = 0; s < 5; s++) mdl.access(s_adr[s], s_dat[s]);
            chk(32'(trig_cnt), m > 8 ? 32'h0 : 32'(e_trg[m]));
            bus(1'b0, `DBT_OFS_STAT, 32'h0);
            chk(q & {24'h0, msk}, m > 8 ? 32'h20 : {24'h0, e_st[m] & msk});
            bw(`DBT_OFS_CTRL, 32'h00);
        end
        $display("test modes done");
        // tag type: a plain access must not trigger, the executed opcode must; both opcodes are captured
        bw(`DBT_OFS_TRIG, 32'h80);
        bw(`DBT_OFS_CTRL, 32'hc0);
        trig_cnt = 0;
        mdl.access(16'h1000, 8'h00);
        mdl.exec(16'h0ff0);
        mdl.exec(16'h1000);
        chk(32'(trig_cnt), 32'h1);
        br(`DBT_OFS_STAT, 32'h82);
        $display("test tag done");
        // begin trace fills eight words, ninth opcode runs after the stop
        bw(`DBT_OFS_TRIG, 32'h40);
        bw(`DBT_OFS_CTRL, 32'hc0);
        mdl.exec(16'h0100);
        mdl.access(16'h1000, 8'h00);
        for (int i = 0; i < 9; i++) mdl.exec(16'h0200 + 16'(i));
        br(`DBT_OFS_STAT, 32'h88);
        // count is eight so nothing is discarded; the ninth read returns the last opcode address pushed by a low byte read
        for (int i = 0; i < 9; i++) begin
            br(`DBT_OFS_FIFO_HI, 32'h02);
            br(`DBT_OFS_FIFO_LO, 32'(i));
        end
        br(`DBT_OFS_STAT, 32'h88);
        $display("test fifo done");
        stop_test();
    end
endmodule : tb_top

bind dbt_top dbt_top_props #(.DEPTH(DEPTH)) u_props (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
    .hrdata_out(hrdata_out), .cpu_bus_in(cpu_bus_in), .cpu_exec_in(cpu_exec_in),
    .armed_out(armed_out), .trigger_out(trigger_out)
);

/* File: hw/dbt_top.sv */
// debug trigger control and run status with an ahb-lite register slave
`timescale 1ns/1ps
`include "dbt_map.svh"
module dbt_top
    import dbt_pkg::*;
#(
    parameter int DEPTH = 8
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire dbt_cpu_bus_s cpu_bus_in,
    input wire dbt_exec_s cpu_exec_in,
    output logic armed_out,
    output logic trigger_out
);

    localparam logic [3:0] FULL_CNT = 4'(DEPTH);

    // register state
    logic [15:0] comp_a;
    logic [15:0] comp_b;
    logic enable;
    logic [5:0] ctrl_low;
    logic [7:0] trace_trigger_control;
    logic comp_a_match_flag;
    logic comp_b_match_flag;
    logic [3:0] valid_word_count;
    logic a_seen;
    logic [15:0] last_exec_addr;
    dbt_state_e state;
    dbt_state_e next_state;

    // bus data phase bookkeeping
    logic wr_pend;
    logic [`DBT_OFS_W-1:0] wr_ofs;
    logic [31:0] next_rdata;
    logic [15:0] fifo_head;

    // address phase decode
    wire logic [`DBT_OFS_W-1:0] ofs = haddr_in[`DBT_OFS_W-1:0];
    wire logic addr_take = hsel_in & hready_in & htrans_in[1];
    wire logic rd_take = addr_take & ~hwrite_in;
    wire logic rd_fifo_lo = rd_take & (ofs == `DBT_OFS_FIFO_LO);

    // data phase write strobes; status has no strobe at all
    wire logic [7:0] wbyte = hwdata_in[7:0];
    wire logic wr_ctrl = wr_pend & (wr_ofs == `DBT_OFS_CTRL);
    wire logic wr_trig = wr_pend & (wr_ofs == `DBT_OFS_TRIG);
    wire logic wr_comp_a = wr_pend & (wr_ofs == `DBT_OFS_COMP_A);
    wire logic wr_comp_b = wr_pend & (wr_ofs == `DBT_OFS_COMP_B);

    // trigger register fields
    wire logic [3:0] mode = trace_trigger_control[3:0];
    wire logic tag_sel = trace_trigger_control[`DBT_TRIG_TSEL];
    wire logic ev_mode = (mode == `DBT_MODE_EV_B) | (mode == `DBT_MODE_A_THEN_EV_B);
    wire logic begin_trace = trace_trigger_control[`DBT_TRIG_BEGIN] | ev_mode;
    wire logic full_mode = (mode == `DBT_MODE_A_AND_DB) | (mode == `DBT_MODE_A_NOT_DB);

    // run control
    wire logic armed = (state != DBT_ST_IDLE);
    wire logic run_start = wr_ctrl & wbyte[`DBT_CTRL_EN] & wbyte[`DBT_CTRL_ARM] & ~armed;
    wire logic run_stop_sw = wr_ctrl & ~(wbyte[`DBT_CTRL_EN] & wbyte[`DBT_CTRL_ARM]);

    // comparator source: executed opcode in tag type, raw bus access in force type
    wire logic src_valid = tag_sel ? cpu_exec_in.valid : cpu_bus_in.valid;
    wire logic [15:0] src_addr = tag_sel ? cpu_exec_in.addr : cpu_bus_in.addr;
    wire logic hit_a = src_valid & (src_addr == comp_a);
    wire logic hit_b = src_valid & (src_addr == comp_b);

    // full modes look at one bus cycle: address against A, data against B
    wire logic bus_a = cpu_bus_in.valid & (cpu_bus_in.addr == comp_a);
    wire logic data_b = cpu_bus_in.valid & (cpu_bus_in.data == comp_b[7:0]);
    wire logic in_rng = src_valid & (src_addr >= comp_a) & (src_addr <= comp_b);
    wire logic out_rng = src_valid & ((src_addr < comp_a) | (src_addr > comp_b));

    // mode decoder; unknown codes fall to no trigger
    function automatic logic dbt_mode_trig(
        input logic [3:0] m,
        input logic ha,
        input logic hb,
        input logic seen,
        input logic ba,
        input logic db,
        input logic inr,
        input logic outr
    );
        logic t;
        t = 1'b0;
        case (m)
            `DBT_MODE_A_ONLY: t = ha;
            `DBT_MODE_A_OR_B: t = ha | hb;
            `DBT_MODE_A_THEN_B: t = seen & hb;
            `DBT_MODE_A_AND_DB: t = ba & db;
            `DBT_MODE_A_NOT_DB: t = ba & ~db;
            `DBT_MODE_INSIDE: t = inr;
            `DBT_MODE_OUTSIDE: t = outr;
            default: t = 1'b0;
        endcase
        return t;
    endfunction : dbt_mode_trig

    wire logic trig = armed & dbt_mode_trig(mode, hit_a, hit_b, a_seen, bus_a, data_b, in_rng, out_rng);

    // events worth storing in the event modes; A must come first in mode four
    // gated by the event modes so in any other mode a B hit pulses the trigger only through the mode decoder
    wire logic ev_hit = armed & ev_mode & hit_b & ((mode == `DBT_MODE_EV_B) | a_seen);

    // capture pushes: pre-trigger circular fill or post-trigger store
    wire logic push_wait = (state == DBT_ST_WAIT) & ~begin_trace & cpu_exec_in.valid;
    wire logic push_store = (state == DBT_ST_STORE) & (ev_mode ? ev_hit : cpu_exec_in.valid);
    wire logic cap_push = push_wait | push_store;
    wire logic [15:0] cap_data = ev_mode ? {8'h00, cpu_bus_in.data} : cpu_exec_in.addr;

    // reading the low byte while disarmed pushes the last opcode address
    wire logic prof_push = rd_fifo_lo & ~armed;
    wire logic fifo_push = cap_push | prof_push;
    wire logic [15:0] fifo_data = armed ? cap_data : last_exec_addr;

    // count saturates at the depth; only capture pushes move it
    wire logic cnt_full = (valid_word_count == FULL_CNT);
    wire logic [3:0] cnt_inc = cnt_full ? valid_word_count : valid_word_count + 4'h1;
    wire logic store_fills = push_store & (cnt_inc == FULL_CNT);

    // status and control images
    wire logic arm_image = armed & enable;
    wire logic [7:0] stat_byte = {comp_a_match_flag, comp_b_match_flag, arm_image, 1'b0, valid_word_count};
    wire logic [7:0] ctrl_byte = {enable, armed, ctrl_low};

    dbt_trace_fifo #(
        .WIDTH(16),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock_in(clock_in),
        .reset_n_in(reset_n_in),
        .push_in(fifo_push),
        .push_data_in(fifo_data),
        .head_out(fifo_head)
    );

    // run sequencer; a software stop beats any automatic transition
    always_comb begin
        next_state = state;
        case (state)
            DBT_ST_IDLE: begin
                if (run_start) begin
                    next_state = ev_mode ? DBT_ST_STORE : DBT_ST_WAIT;
                end
            end
            DBT_ST_WAIT: begin
                if (trig) begin
                    next_state = begin_trace ? DBT_ST_STORE : DBT_ST_IDLE;
                end
            end
            DBT_ST_STORE: begin
                if (store_fills) begin
                    next_state = DBT_ST_IDLE;
                end
            end
            default: begin
                next_state = DBT_ST_IDLE;
            end
        endcase
        if (run_stop_sw) begin
            next_state = DBT_ST_IDLE;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            state <= DBT_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // read mux, sampled at the address phase edge
    always_comb begin
        next_rdata = `DBT_RST_WORD;
        if (ofs == `DBT_OFS_COMP_A) begin
            next_rdata = {16'h0000, comp_a};
        end else if (ofs == `DBT_OFS_COMP_B) begin
            next_rdata = {16'h0000, comp_b};
        end else if (ofs == `DBT_OFS_FIFO_HI) begin
            next_rdata = {24'h000000, fifo_head[15:8]};
        end else if (ofs == `DBT_OFS_FIFO_LO) begin
            next_rdata = {24'h000000, fifo_head[7:0]};
        end else if (ofs == `DBT_OFS_CTRL) begin
            next_rdata = {24'h000000, ctrl_byte};
        end else if (ofs == `DBT_OFS_TRIG) begin
            next_rdata = {24'h000000, trace_trigger_control};
        end else if (ofs == `DBT_OFS_STAT) begin
            next_rdata = {24'h000000, stat_byte};
        end
    end

    // ahb slave: zero wait states, always okay
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            hrdata_out <= `DBT_RST_WORD;
            hreadyout_out <= 1'b1;
            hresp_out <= `DBT_HRESP_OKAY;
            wr_pend <= 1'b0;
            wr_ofs <= '0;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out <= `DBT_HRESP_OKAY;
            wr_pend <= addr_take & hwrite_in;
            wr_ofs <= ofs;
            if (rd_take) begin
                hrdata_out <= next_rdata;
            end
        end
    end

    // comparator address registers
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            comp_a <= `DBT_RST_ADDR;
            comp_b <= `DBT_RST_ADDR;
        end else begin
            if (wr_comp_a) begin
                comp_a <= hwdata_in[15:0];
            end
            if (wr_comp_b) begin
                comp_b <= hwdata_in[15:0];
            end
        end
    end

    // control bits; arm itself lives in the sequencer state
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            enable <= 1'b0;
            ctrl_low <= 6'h00;
        end else if (wr_ctrl) begin
            enable <= wbyte[`DBT_CTRL_EN];
            ctrl_low <= wbyte[5:0];
        end
    end

    // trigger register locked while a run is armed, bits 4 and 5 kept zero
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            trace_trigger_control <= `DBT_RST_BYTE;
        end else if (wr_trig & ~armed) begin
            trace_trigger_control <= wbyte & `DBT_TRIG_WMASK;
        end
    end

    // match flags: start clears, later matches set
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            comp_a_match_flag <= 1'b0;
            comp_b_match_flag <= 1'b0;
            a_seen <= 1'b0;
        end else if (run_start) begin
            comp_a_match_flag <= 1'b0;
            comp_b_match_flag <= 1'b0;
            a_seen <= 1'b0;
        end else if (armed) begin
            if (hit_a | (full_mode & bus_a)) begin
                comp_a_match_flag <= 1'b1;
                a_seen <= 1'b1;
            end
            if (full_mode ? data_b : hit_b) begin
                comp_b_match_flag <= 1'b1;
            end
        end
    end

    // valid count: profiling reads leave it alone so the host must keep its own tally
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            valid_word_count <= `DBT_RST_CNT;
        end else if (run_start) begin
            valid_word_count <= `DBT_RST_CNT;
        end else if (cap_push) begin
            valid_word_count <= cnt_inc;
        end
    end

    // last executed opcode address feeds the profiling pushes
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            last_exec_addr <= `DBT_RST_ADDR;
        end else if (cpu_exec_in.valid) begin
            last_exec_addr <= cpu_exec_in.addr;
        end
    end

    // side outputs, registered
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            armed_out <= 1'b0;
            trigger_out <= 1'b0;
        end else begin
            armed_out <= (next_state != DBT_ST_IDLE) & ~run_stop_sw;
            trigger_out <= trig | ev_hit;
        end
    end

endmodule : dbt_top

/* File: hw/dbt_trace_fifo.sv */
// eight word shift register trace fifo, oldest word at the head
`timescale 1ns/1ps
module dbt_trace_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic push_in,
    input wire logic [WIDTH-1:0] push_data_in,
    output logic [WIDTH-1:0] head_out
);

    logic [WIDTH-1:0] mem [DEPTH];

    // every push shifts the whole line one place toward the head
    genvar i;
    for (i = 0; i < DEPTH; i++) begin : g_slot
        if (i == DEPTH - 1) begin : g_tail
            always_ff @(posedge clock_in) begin
                if (!reset_n_in) begin
                    mem[i] <= '0;
                end else if (push_in) begin
                    mem[i] <= push_data_in;
                end
            end
        end else begin : g_body
            always_ff @(posedge clock_in) begin
                if (!reset_n_in) begin
                    mem[i] <= '0;
                end else if (push_in) begin
                    mem[i] <= mem[i+1];
                end
            end
        end
    end

    // head is the word the next low byte read returns
    assign head_out = mem[0];

endmodule : dbt_trace_fifo

/* File: shared/dbt_map.svh */
// register offsets, field positions, mode codes and reset values of the debug trigger block
`ifndef DBT_MAP_SVH
`define DBT_MAP_SVH

// byte offsets of the register words, decoded on haddr[11:0]
`define DBT_OFS_COMP_A 12'h000
`define DBT_OFS_COMP_B 12'h004
`define DBT_OFS_FIFO_HI 12'h008
`define DBT_OFS_FIFO_LO 12'h00c
`define DBT_OFS_CTRL 12'h010
`define DBT_OFS_TRIG 12'h014
`define DBT_OFS_STAT 12'h018
`define DBT_OFS_W 12

// debug_control_reg fields
`define DBT_CTRL_EN 7
`define DBT_CTRL_ARM 6
// trace_trigger_control fields
`define DBT_TRIG_TSEL 7
`define DBT_TRIG_BEGIN 6
`define DBT_TRIG_WMASK 8'hcf

// trigger_mode_field codes
`define DBT_MODE_A_ONLY 4'h0
`define DBT_MODE_A_OR_B 4'h1
`define DBT_MODE_A_THEN_B 4'h2
`define DBT_MODE_EV_B 4'h3
`define DBT_MODE_A_THEN_EV_B 4'h4
`define DBT_MODE_A_AND_DB 4'h5
`define DBT_MODE_A_NOT_DB 4'h6
`define DBT_MODE_INSIDE 4'h7
`define DBT_MODE_OUTSIDE 4'h8

// reset values
`define DBT_RST_BYTE 8'h00
`define DBT_RST_ADDR 16'h0000
`define DBT_RST_CNT 4'h0
`define DBT_RST_WORD 32'h0000_0000
`define DBT_HRESP_OKAY 1'b0

`endif

/* File: shared/dbt_pkg.sv */
// types shared by the debug trigger block
package dbt_pkg;

    // one cpu bus cycle as the block sees it
    typedef struct packed {
        logic valid;
        logic rw;
        logic [15:0] addr;
        logic [7:0] data;
    } dbt_cpu_bus_s;

    // one executed opcode and the address it was fetched from
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } dbt_exec_s;

    // run sequencer states, one-hot
    typedef enum logic [2:0] {
        DBT_ST_IDLE = 3'b001,
        DBT_ST_WAIT = 3'b010,
        DBT_ST_STORE = 3'b100
    } dbt_state_e;

endpackage : dbt_pkg
